/* rbmc_mcu.sv */
// controller model driving the register port
`timescale 1ns/1ps
module rbmc_mcu (
    // clock
    input  wire logic       MCLK,
    // register port
    output logic            we,
    output logic      [5:0] addr,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    // ****
    // bus tasks
    // ****
    initial begin
        we = 1'b0;
        addr = 6'h00;
        wdata = 8'h00;
    end
    // write one byte, reserved bits kept zero
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge MCLK);
        #1;
        we = 1'b1;
        addr = a;
        wdata = (a == 6'h03) ? (d & 8'hFC) : (a == 6'h04) ? (d & 8'h07) : d;
        @(posedge MCLK);
        #1;
        we = 1'b0;
        wdata = ~wdata; // released data no longer shows the value
    endtask
    // read one byte
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge MCLK);
        #1;
        addr = a;
        #2;
        d = rdata;
    endtask
endmodule

/* rbmc_pkg.sv */
// constants for the radio baseband mode configuration block
package rbmc_pkg;
    // ****************************************
    // register offsets on the parallel register port
    // ****************************************
    localparam logic [5:0] ADDR_RADIO_CONTROL  = 6'h03;
    localparam logic [5:0] ADDR_CODE_RATE_SEL  = 6'h04;
    localparam logic [5:0] ADDR_SETTLE_COUNT   = 6'h38;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_RADIO_CONTROL   = 8'h00;
    localparam logic [7:0] RST_CODE_RATE_SEL   = 8'h00;
    localparam logic [7:0] RST_SETTLE_COUNT    = 8'h64;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTL_RX_EN       = 7;
    localparam int CTL_TX_EN       = 6;
    localparam int CTL_HALF_SEL    = 5;
    localparam int CTL_LOCK_BYPASS = 4;
    localparam int CTL_AMP_MANUAL  = 3;
    localparam int CTL_AMP_ON      = 2;
    localparam int RATE_CODE_32    = 2;
    localparam int RATE_DOUBLE     = 1;
    localparam int RATE_SAMPLE_12X = 0;
    localparam logic [7:0] CTL_WRITE_MASK  = 8'hFC;
    localparam logic [7:0] RATE_WRITE_MASK = 8'h07;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ        = 100;
    localparam int TICK_US        = 2;
    localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
endpackage

/* rbmc_tb_top.sv */
// testbench for the mode configuration block
`timescale 1ns/1ps
module rbmc_tb_top;
    logic       mclk, rst_n, we, start, lock, req, done, busy, amp, rx, tx, upper, c32, dbl, s12;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, v;
    int         n_fail = 0, cmp_count = 0, n;
    logic [13:0] rst_tab [4] = '{14'h0300, 14'h0400, 14'h3864, 14'h0500};
    logic [9:0] amp_tab [6] = '{10'h003, 10'h010, 10'h031, 10'h022, 10'h133, 10'h000};
    logic [2:0] rates [4] = '{3'h0, 3'h5, 3'h6, 3'h4};
    // ****
    // design, controller, clock
    // ****
    rbmc_top rbmc_top_i (.MCLK(mclk), .RST_N(rst_n), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .SETTLE_START(start), .SYN_LOCK(lock), .SETTLE_DONE(done), .SETTLE_BUSY(busy),
        .AUTO_AMP_REQ(req), .AMP_ENABLE(amp), .RX_MODE(rx), .TX_MODE(tx), .USE_UPPER_HALF(upper),
        .CODE_32_CHIPS(c32), .DOUBLE_RATE(dbl), .SAMPLE_12X(s12));
    rbmc_mcu rbmc_mcu_i (.MCLK(mclk), .we(we), .addr(addr), .wdata(wdata), .rdata(rdata));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // helpers
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d fails %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // start a settle wait, a second start at 100 must be ignored
    task automatic settle(input int lock_at);
        start = 1'b1;
        n = 0;
        while (n < 6000 && done !== 1'b1) begin
            step(1);
            n++;
            start = (n == 100);
            lock = (n >= lock_at);
        end
        if (n >= 6000) begin
            n_fail++;
            finish_test();
        end
    endtask
    // ****
    // tests
    // ****
    initial begin
        {rst_n, start, lock, req} = 4'h0;
        step(8);
        rst_n = 1'b1;
        check("outs", {rx, tx, upper, c32, dbl, s12, amp, busy}, 8'h00);
        foreach (rst_tab[i]) begin
            rbmc_mcu_i.rd(rst_tab[i][13:8], v);
            check("reset reg", v, rst_tab[i][7:0]);
        end
        $display("reset test done");
        rbmc_mcu_i.wr(6'h03, 8'hA0);
        foreach (rates[i]) begin
            rbmc_mcu_i.wr(6'h04, {5'h00, rates[i]});
            rbmc_mcu_i.rd(6'h04, v);
            check("rate reg", v, {5'h00, rates[i]});
            check("modes", {2'b00, rx, tx, upper, c32, dbl, s12}, {4'h2, rates[i][2], rates[i][2],
                &rates[i][2:1], rates[i][2] & ~rates[i][1] & rates[i][0]});
        end
        $display("rate test done");
        foreach (amp_tab[i]) begin
            rbmc_mcu_i.wr(6'h03, amp_tab[i][9:2]);
            req = amp_tab[i][1];
            step(2);
            check("amp", {4'h0, rx, tx, upper, amp}, {4'h0, amp_tab[i][9:8], 1'b0, amp_tab[i][0]});
        end
        $display("amp test done");
        rbmc_mcu_i.wr(6'h03, 8'h10);
        rbmc_mcu_i.wr(6'h38, 8'h02);
        settle(9999);
        check("bypass wait", {7'h00, n inside {[401:406]}}, 8'h01);
        rbmc_mcu_i.wr(6'h03, 8'h00);
        rbmc_mcu_i.wr(6'h38, 8'h19);
        settle(300);
        check("lock wait", {7'h00, n inside {[5300:5310]}}, 8'h01);
        $display("settle test done");
        finish_test();
    end
endmodule

/* rbmc_tick.sv */
// divider producing a one-cycle enable every 2 us
`timescale 1ns/1ps
module rbmc_tick (
    // clock and reset
    input  wire logic MCLK,
    input  wire logic RST_N,
    // control
    input  wire logic clr,
    output logic      tick
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // count cycles, restart on clear
    always_comb begin
        tick = (cnt_q == rbmc_pkg::TICK_LAST);
        if (clr || tick) begin
            cnt_d = 8'h00;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    // register counter
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

/* rbmc_top.sv */
// mode configuration registers and synthesizer settle sequencer
`timescale 1ns/1ps
module rbmc_top (
    // clock and reset
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    // register write/read port
    input  wire logic       REG_WE,
    input  wire logic [5:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    // synthesizer settle sequencing
    input  wire logic       SETTLE_START,
    input  wire logic       SYN_LOCK,
    output logic            SETTLE_DONE,
    output logic            SETTLE_BUSY,
    // baseband amplifier request
    input  wire logic       AUTO_AMP_REQ,
    output logic            AMP_ENABLE,
    // mode outputs
    output logic            RX_MODE,
    output logic            TX_MODE,
    output logic            USE_UPPER_HALF,
    output logic            CODE_32_CHIPS,
    output logic            DOUBLE_RATE,
    output logic            SAMPLE_12X
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOCK = 3'b010,
        ST_WAIT = 3'b100
    } rbmc_state_t;

    // ****************************************
    // internal state
    // ****************************************

    // register contents and their next values
    logic [7:0]  ctl_q;
    logic [7:0]  ctl_d;
    logic [7:0]  rate_q;
    logic [7:0]  rate_d;
    logic [7:0]  settle_q;
    logic [7:0]  settle_d;
    // settle sequencer
    rbmc_state_t st_q;
    rbmc_state_t st_d;
    logic [7:0]  down_q;
    logic [7:0]  down_d;
    logic        done_q;
    logic        done_d;
    logic        tick;                 // one cycle every 2 us while waiting
    // two-flop synchroniser for the analog lock level
    logic        lock_s1_q;
    logic        lock_q;
    // mode outputs, bit 0 receive up to bit 6 amplifier
    logic [6:0]  out_q;
    logic [6:0]  out_d;

    // ****************************************
    // registers
    // ****************************************

    // register writes, reserved bits held at zero
    always_comb begin
        ctl_d    = ctl_q;
        rate_d   = rate_q;
        settle_d = settle_q;
        if (REG_WE) begin
            case (REG_ADDR)
                rbmc_pkg::ADDR_RADIO_CONTROL: ctl_d = REG_WDATA & rbmc_pkg::CTL_WRITE_MASK;
                rbmc_pkg::ADDR_CODE_RATE_SEL: rate_d = REG_WDATA & rbmc_pkg::RATE_WRITE_MASK;
                rbmc_pkg::ADDR_SETTLE_COUNT:  settle_d = REG_WDATA;
                default: ;
            endcase
        end
    end

    // read mux
    always_comb begin
        case (REG_ADDR)
            rbmc_pkg::ADDR_RADIO_CONTROL: REG_RDATA = ctl_q;
            rbmc_pkg::ADDR_CODE_RATE_SEL: REG_RDATA = rate_q;
            rbmc_pkg::ADDR_SETTLE_COUNT:  REG_RDATA = settle_q;
            default:                      REG_RDATA = 8'h00;
        endcase
    end

    // ****************************************
    // mode decode
    // ****************************************

    // mode outputs registered from the settings, the amplifier from the request input in auto mode
    always_comb begin
        out_d = 7'h00;
        out_d[0] = ctl_q[rbmc_pkg::CTL_RX_EN];
        out_d[1] = ctl_q[rbmc_pkg::CTL_TX_EN];
        out_d[2] = rate_q[rbmc_pkg::RATE_CODE_32];
        out_d[3] = rate_q[rbmc_pkg::RATE_CODE_32] && ctl_q[rbmc_pkg::CTL_HALF_SEL];
        out_d[4] = rate_q[rbmc_pkg::RATE_CODE_32] && rate_q[rbmc_pkg::RATE_DOUBLE];
        out_d[5] = rate_q[rbmc_pkg::RATE_CODE_32] && !rate_q[rbmc_pkg::RATE_DOUBLE]
                   && rate_q[rbmc_pkg::RATE_SAMPLE_12X];
        if (ctl_q[rbmc_pkg::CTL_AMP_MANUAL]) begin
            out_d[6] = ctl_q[rbmc_pkg::CTL_AMP_ON];
        end else begin
            out_d[6] = AUTO_AMP_REQ;
        end
    end

    assign RX_MODE        = out_q[0];
    assign TX_MODE        = out_q[1];
    assign CODE_32_CHIPS  = out_q[2];
    assign USE_UPPER_HALF = out_q[3];
    assign DOUBLE_RATE    = out_q[4];
    assign SAMPLE_12X     = out_q[5];
    assign AMP_ENABLE     = out_q[6];

    // ****************************************
    // settle sequencer
    // ****************************************

    // divider held clear outside the wait state, so the first tick falls
    // a full 2 us after counting starts, also after a lock wait
    rbmc_tick rbmc_tick_i (
        .MCLK  (MCLK),
        .RST_N (RST_N),
        .clr   (st_q != ST_WAIT),
        .tick  (tick)
    );

    // wait for lock (unless bypassed), then count ticks down
    always_comb begin
        st_d   = st_q;
        down_d = down_q;
        done_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (SETTLE_START) begin
                    down_d = settle_q;
                    if (ctl_q[rbmc_pkg::CTL_LOCK_BYPASS]) begin
                        st_d = ST_WAIT;
                    end else begin
                        st_d = ST_LOCK;
                    end
                end
            end
            ST_LOCK: begin
                if (lock_q) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (down_q == 8'h00) begin
                    st_d   = ST_IDLE;
                    done_d = 1'b1;
                end else if (tick) begin
                    down_d = down_q - 8'h01;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    assign SETTLE_DONE = done_q;
    assign SETTLE_BUSY = (st_q != ST_IDLE);

    // register contents
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_q    <= rbmc_pkg::RST_RADIO_CONTROL;
            rate_q   <= rbmc_pkg::RST_CODE_RATE_SEL;
            settle_q <= rbmc_pkg::RST_SETTLE_COUNT;
        end else begin
            ctl_q    <= ctl_d;
            rate_q   <= rate_d;
            settle_q <= settle_d;
        end
    end

    // mode outputs, one cycle behind the registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            out_q <= 7'h00;
        end else begin
            out_q <= out_d;
        end
    end

    // settle sequencer state
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            down_q <= 8'h00;
            st_q   <= ST_IDLE;
            done_q <= 1'b0;
        end else begin
            down_q <= down_d;
            st_q   <= st_d;
            done_q <= done_d;
        end
    end

    // lock synchroniser, only the second stage feeds the sequencer
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            lock_s1_q <= 1'b0;
            lock_q    <= 1'b0;
        end else begin
            lock_s1_q <= SYN_LOCK;   // lock comes from the analog side
            lock_q    <= lock_s1_q;
        end
    end
endmodule

/* rbmc_top_sva.sv */
// assertions on the mode block ports
`timescale 1ns/1ps
module rbmc_chk (
    // clock, reset, register port
    input wire logic       MCLK,
    input wire logic       RST_N,
    input wire logic       REG_WE,
    input wire logic [5:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    // settle and modes
    input wire logic       SETTLE_START,
    input wire logic       SETTLE_DONE,
    input wire logic       SETTLE_BUSY,
    input wire logic       RX_MODE,
    input wire logic       TX_MODE,
    input wire logic       USE_UPPER_HALF,
    input wire logic       CODE_32_CHIPS,
    input wire logic       DOUBLE_RATE,
    input wire logic       SAMPLE_12X,
    // amplifier
    input wire logic       AUTO_AMP_REQ,
    input wire logic       AMP_ENABLE
);
    // ****
    // checks
    // ****
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    chk_half_needs_32:
        assert property (USE_UPPER_HALF |-> CODE_32_CHIPS) else $error("half without 32");
    chk_double_needs_32:
        assert property (DOUBLE_RATE |-> CODE_32_CHIPS) else $error("double without 32");
    chk_sample_normal_32:
        assert property (SAMPLE_12X |-> CODE_32_CHIPS && !DOUBLE_RATE) else $error("bad 12x");
    chk_rate_readback:
        assert property (REG_WE && REG_ADDR == 6'h04 ##1 REG_ADDR == 6'h04
            |-> REG_RDATA == ($past(REG_WDATA) & 8'h07)) else $error("rate readback");
    chk_rx_tx_follow:
        assert property (REG_WE && REG_ADDR == 6'h03 ##1 !REG_WE |=> RX_MODE == $past(REG_WDATA[7], 2)
            && TX_MODE == $past(REG_WDATA[6], 2)) else $error("rx tx mode");
    chk_done_ends_busy:
        assert property (SETTLE_DONE |-> !SETTLE_BUSY && $past(SETTLE_BUSY)) else $error("done");
    chk_start_busy:
        assert property (SETTLE_START && !SETTLE_BUSY |=> SETTLE_BUSY) else $error("start");
    chk_done_pulse:
        assert property (SETTLE_DONE |=> !SETTLE_DONE) else $error("done pulse");
    chk_amp_manual_on:
        assert property (REG_WE && REG_ADDR == 6'h03 && REG_WDATA[3] ##1 !REG_WE
            |=> AMP_ENABLE == $past(REG_WDATA[2], 2)) else $error("amp manual");
    chk_amp_auto_req:
        assert property (REG_WE && REG_ADDR == 6'h03 && !REG_WDATA[3] ##1 !REG_WE
            |=> AMP_ENABLE == $past(AUTO_AMP_REQ)) else $error("amp auto");
endmodule
bind rbmc_top rbmc_chk rbmc_chk_i (.MCLK, .RST_N, .REG_WE, .REG_ADDR, .REG_WDATA, .REG_RDATA,
    .SETTLE_START, .SETTLE_DONE, .SETTLE_BUSY, .RX_MODE, .TX_MODE, .USE_UPPER_HALF,
    .CODE_32_CHIPS, .DOUBLE_RATE, .SAMPLE_12X, .AUTO_AMP_REQ, .AMP_ENABLE);
